// file: rtl/pemux_pkg.sv
package pemux_pkg;
    localparam logic [11:0] PEMUX_OFS_PESEL_LO = 12'h000;
    localparam logic [11:0] PEMUX_OFS_PESEL_HI = 12'h004;
    localparam logic [11:0] PEMUX_OFS_INSRC = 12'h008;
    localparam logic [11:0] PEMUX_OFS_PE_DATA = 12'h00C;
    localparam logic [11:0] PEMUX_OFS_PE_DIR = 12'h010;
    localparam logic [11:0] PEMUX_OFS_PA_DATA = 12'h014;
    localparam logic [11:0] PEMUX_OFS_PA_DIR = 12'h018;
    localparam logic [11:0] PEMUX_OFS_PA_WAKE = 12'h01C;
    localparam logic [11:0] PEMUX_OFS_PE_BITOP = 12'h020;
    localparam logic [11:0] PEMUX_OFS_PE_PINS = 12'h024;
    localparam logic [11:0] PEMUX_OFS_PA_PINS = 12'h028;
    localparam logic [7:0] PEMUX_SEL_RST = 8'h00;
    localparam logic [7:0] PEMUX_PORT_RST = 8'hFF;
    localparam logic [7:0] PEMUX_WAKE_RST = 8'h00;
    localparam logic [1:0] PEMUX_CODE_ALT = 2'h1;
    localparam logic [1:0] PEMUX_SRC_FIRST = 2'h0;
    localparam logic [7:0] PEMUX_INSRC_MASK = 8'hFF;
    localparam int PEMUX_F_BIT0 = 0;
    localparam int PEMUX_F_BIT1 = 2;
    localparam int PEMUX_F_BIT2 = 4;
    localparam int PEMUX_F_BIT3 = 6;
    localparam int PEMUX_BITOP_SET = 3;
    localparam int PEMUX_BITOP_DIR = 4;
    typedef enum logic [1:0] {
        PEMUX_RMW_IDLE = 2'b00,
        PEMUX_RMW_READ = 2'b01,
        PEMUX_RMW_WRITE = 2'b11
    } pemux_rmw_e;
endpackage : pemux_pkg

// file: rtl/pemux_sel2.sv
`timescale 1ns/1ps
`default_nettype none
// picks the alternate source when a two-bit code is anything but the first code
module pemux_sel2
    import pemux_pkg::*;
(
    input wire logic [1:0] code,
    input wire logic first_src,
    input wire logic other_src,
    output logic picked
);
    assign picked = (code == PEMUX_SRC_FIRST) ? first_src : other_src;
endmodule : pemux_sel2
`default_nettype wire

// file: rtl/pemux_wake.sv
`timescale 1ns/1ps
`default_nettype none
module pemux_wake
    import pemux_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] pins,
    input wire logic [WIDTH-1:0] enable,
    input wire logic low_power,
    output logic wake
);
    typedef struct packed {
        logic [WIDTH-1:0] prev;
        logic wake;
    } pemux_wk_s;
    pemux_wk_s st_r, st_nxt;
    logic [WIDTH-1:0] fall;
    genvar g;
    // --------------------------------------------------------------
    // per-pin falling edge, gated by its own enable
    // --------------------------------------------------------------
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pin
            assign fall[g] = enable[g] & st_r.prev[g] & ~pins[g];
        end
    endgenerate
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = pins;
        st_nxt.wake = low_power & (|fall);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{prev: '1, wake: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end
    assign wake = st_r.wake;
endmodule : pemux_wake
`default_nettype wire

// file: rtl/pemux_top.sv
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pemux_top
    import pemux_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] port_e_in,
    output logic [7:0] port_e_out,
    output logic [7:0] port_e_oen,
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oen,
    input wire logic port_c_bit2,
    input wire logic compact_timer1_output,
    input wire logic standard_timer0_output,
    input wire logic uart_tx,
    output logic compact_timer1_clock_input,
    output logic standard_timer0_clock_input,
    output logic standard_timer0_capture_input,
    output logic periodic_timer0_capture_input,
    output logic periodic_timer1_capture_input,
    output logic uart_rx,
    input wire logic low_power,
    output logic wake
);
    typedef struct packed {
        logic [7:0] pesel_lo;
        logic [7:0] pesel_hi;
        logic [7:0] insrc;
        logic [7:0] pe_data;
        logic [7:0] pe_dir;
        logic [7:0] pa_data;
        logic [7:0] pa_dir;
        logic [7:0] pa_wake;
        pemux_rmw_e rmw;
        logic [4:0] rmw_op;
        logic [7:0] rmw_byte;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] pe_out;
        logic [7:0] pe_oen;
        logic [7:0] pa_out;
        logic [7:0] pa_oen;
        logic ct1_clk;
        logic st0_clk;
        logic st0_cap;
        logic pt0_cap;
        logic pt1_cap;
        logic rx;
    } pemux_st_s;

    pemux_st_s st_r, st_nxt;
    logic [1:0] f0, f1, f2, f3, f5, f6;
    logic st0_cap_pick, pt0_cap_pick, pt1_cap_pick, rx_pick;
    logic [7:0] pe_drv, pe_alt, pe_alt_oe, rd_byte;
    logic setup, access, hit;

    // --------------------------------------------------------------
    // field views of the select registers
    // --------------------------------------------------------------
    assign f0 = st_r.pesel_lo[PEMUX_F_BIT0 +: 2];
    assign f1 = st_r.pesel_lo[PEMUX_F_BIT1 +: 2];
    assign f2 = st_r.pesel_lo[PEMUX_F_BIT2 +: 2];
    assign f3 = st_r.pesel_lo[PEMUX_F_BIT3 +: 2];
    assign f5 = st_r.pesel_hi[PEMUX_F_BIT1 +: 2];
    assign f6 = st_r.pesel_hi[PEMUX_F_BIT2 +: 2];

    // --------------------------------------------------------------
    // input source selection
    // --------------------------------------------------------------
    pemux_sel2 u_rx_src (
        .code(st_r.insrc[7:6]),
        .first_src(port_c_bit2),
        .other_src(port_e_in[1]),
        .picked(rx_pick)
    );
    pemux_sel2 u_pt1_src (
        .code(st_r.insrc[5:4]),
        .first_src(port_a_in[3]),
        .other_src(port_a_in[4]),
        .picked(pt1_cap_pick)
    );
    pemux_sel2 u_pt0_src (
        .code(st_r.insrc[3:2]),
        .first_src(port_a_in[0]),
        .other_src(port_a_in[1]),
        .picked(pt0_cap_pick)
    );
    pemux_sel2 u_st0_src (
        .code(st_r.insrc[1:0]),
        .first_src(port_e_in[5]),
        .other_src(port_e_in[6]),
        .picked(st0_cap_pick)
    );

    pemux_wake #(
        .WIDTH(8)
    ) u_wake (
        .pclk(pclk),
        .presetn(presetn),
        .pins(port_a_in),
        .enable(st_r.pa_wake),
        .low_power(low_power),
        .wake(wake)
    );

    // --------------------------------------------------------------
    // port E output function
    // --------------------------------------------------------------
    // a timer output only reaches its pin once the field is programmed
    always_comb begin
        pe_alt = 8'h00;
        pe_alt_oe = 8'h00;
        if (f0 == PEMUX_CODE_ALT) begin
            pe_alt[0] = uart_tx;
            pe_alt_oe[0] = 1'b1;
        end
        if (f3 == PEMUX_CODE_ALT) begin
            pe_alt[3] = compact_timer1_output;
            pe_alt_oe[3] = 1'b1;
        end
        if (f5 == PEMUX_CODE_ALT) begin
            pe_alt[5] = standard_timer0_output;
            pe_alt_oe[5] = 1'b1;
        end
        if (f6 == PEMUX_CODE_ALT) begin
            pe_alt[6] = standard_timer0_output;
            pe_alt_oe[6] = 1'b1;
        end
    end
    // bit 1 in receive mode still drives when its pe_dir bit is clear; bits 2, 4, 7 are never driven by a function
    assign pe_drv = pe_alt_oe | ~st_r.pe_dir;

    // --------------------------------------------------------------
    // APB read mux
    // --------------------------------------------------------------
    assign setup = psel & ~penable;
    assign access = psel & penable;
    always_comb begin
        hit = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            PEMUX_OFS_PESEL_LO: rd_byte = st_r.pesel_lo;
            PEMUX_OFS_PESEL_HI: rd_byte = st_r.pesel_hi;
            PEMUX_OFS_INSRC: rd_byte = st_r.insrc & PEMUX_INSRC_MASK;
            PEMUX_OFS_PE_DATA: rd_byte = st_r.pe_data;
            PEMUX_OFS_PE_DIR: rd_byte = st_r.pe_dir;
            PEMUX_OFS_PA_DATA: rd_byte = st_r.pa_data;
            PEMUX_OFS_PA_DIR: rd_byte = st_r.pa_dir;
            PEMUX_OFS_PA_WAKE: rd_byte = st_r.pa_wake;
            PEMUX_OFS_PE_BITOP: rd_byte = 8'h00;
            PEMUX_OFS_PE_PINS: rd_byte = port_e_in;
            PEMUX_OFS_PA_PINS: rd_byte = port_a_in;
            default: hit = 1'b0;
        endcase
    end

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        case (st_r.rmw)
            PEMUX_RMW_IDLE: begin
                if (setup && paddr == PEMUX_OFS_PE_BITOP && pwrite) begin
                    st_nxt.rmw_op = pwdata[4:0];
                    st_nxt.rmw = PEMUX_RMW_READ;
                end else if (access && !st_r.pready) begin
                    st_nxt.pready = 1'b1;
                    st_nxt.pslverr = ~hit;
                    st_nxt.prdata = {24'h000000, rd_byte};
                    if (pwrite && hit) begin
                        case (paddr)
                            PEMUX_OFS_PESEL_LO: st_nxt.pesel_lo = pwdata[7:0];
                            PEMUX_OFS_PESEL_HI: st_nxt.pesel_hi = pwdata[7:0];
                            PEMUX_OFS_INSRC: st_nxt.insrc = pwdata[7:0] & PEMUX_INSRC_MASK;
                            PEMUX_OFS_PE_DATA: st_nxt.pe_data = pwdata[7:0];
                            PEMUX_OFS_PE_DIR: st_nxt.pe_dir = pwdata[7:0];
                            PEMUX_OFS_PA_DATA: st_nxt.pa_data = pwdata[7:0];
                            PEMUX_OFS_PA_DIR: st_nxt.pa_dir = pwdata[7:0];
                            PEMUX_OFS_PA_WAKE: st_nxt.pa_wake = pwdata[7:0];
                            default: st_nxt.pslverr = 1'b0;
                        endcase
                    end
                end
            end
            PEMUX_RMW_READ: begin
                // whole-port read: data uses pin levels, direction uses its register
                st_nxt.rmw_byte = st_r.rmw_op[PEMUX_BITOP_DIR] ? st_r.pe_dir : port_e_in;
                st_nxt.rmw_byte[st_r.rmw_op[2:0]] = st_r.rmw_op[PEMUX_BITOP_SET];
                st_nxt.rmw = PEMUX_RMW_WRITE;
            end
            PEMUX_RMW_WRITE: begin
                if (st_r.rmw_op[PEMUX_BITOP_DIR]) begin
                    st_nxt.pe_dir = st_r.rmw_byte;
                end else begin
                    st_nxt.pe_data = st_r.rmw_byte;
                end
                st_nxt.pready = 1'b1;
                st_nxt.prdata = 32'h00000000;
                st_nxt.rmw = PEMUX_RMW_IDLE;
            end
            default: st_nxt.rmw = PEMUX_RMW_IDLE;
        endcase
        // bit op word: [2:0] bit, [3] value, [4] target direction
        st_nxt.rmw_op = (st_r.rmw == PEMUX_RMW_IDLE) ? st_nxt.rmw_op : st_r.rmw_op;
        // pins
        st_nxt.pe_out = (pe_alt_oe & pe_alt) | (~pe_alt_oe & st_r.pe_data);
        st_nxt.pe_oen = ~pe_drv;
        st_nxt.pa_out = st_r.pa_data;
        st_nxt.pa_oen = st_r.pa_dir;
        st_nxt.ct1_clk = port_e_in[2];
        st_nxt.st0_clk = port_e_in[4];
        st_nxt.st0_cap = st0_cap_pick;
        st_nxt.pt0_cap = pt0_cap_pick;
        st_nxt.pt1_cap = pt1_cap_pick;
        st_nxt.rx = (st_r.insrc[7:6] == PEMUX_SRC_FIRST) ? rx_pick
                  : ((f1 == PEMUX_CODE_ALT) ? rx_pick : 1'b1);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{
                pesel_lo: PEMUX_SEL_RST,
                pesel_hi: PEMUX_SEL_RST,
                insrc: PEMUX_SEL_RST,
                pe_data: PEMUX_PORT_RST,
                pe_dir: PEMUX_PORT_RST,
                pa_data: PEMUX_PORT_RST,
                pa_dir: PEMUX_PORT_RST,
                pa_wake: PEMUX_WAKE_RST,
                rmw: PEMUX_RMW_IDLE,
                rmw_op: 5'h00,
                rmw_byte: 8'h00,
                prdata: 32'h00000000,
                pready: 1'b0,
                pslverr: 1'b0,
                pe_out: PEMUX_PORT_RST,
                pe_oen: PEMUX_PORT_RST,
                pa_out: PEMUX_PORT_RST,
                pa_oen: PEMUX_PORT_RST,
                ct1_clk: 1'b0,
                st0_clk: 1'b0,
                st0_cap: 1'b0,
                pt0_cap: 1'b0,
                pt1_cap: 1'b0,
                rx: 1'b1
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign port_e_out = st_r.pe_out;
    assign port_e_oen = st_r.pe_oen;
    assign port_a_out = st_r.pa_out;
    assign port_a_oen = st_r.pa_oen;
    assign compact_timer1_clock_input = st_r.ct1_clk;
    assign standard_timer0_clock_input = st_r.st0_clk;
    assign standard_timer0_capture_input = st_r.st0_cap;
    assign periodic_timer0_capture_input = st_r.pt0_cap;
    assign periodic_timer1_capture_input = st_r.pt1_cap;
    assign uart_rx = st_r.rx;
endmodule : pemux_top
`default_nettype wire

// file: verif/pemux_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port e pin mux checker
// ----------------------------------------
module pemux_chk
    import pemux_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] port_e_in,
    input wire logic [7:0] port_e_out,
    input wire logic [7:0] port_e_oen,
    input wire logic [7:0] port_a_in,
    input wire logic [7:0] port_a_oen,
    input wire logic port_c_bit2,
    input wire logic compact_timer1_output,
    input wire logic uart_tx,
    input wire logic compact_timer1_clock_input,
    input wire logic standard_timer0_capture_input,
    input wire logic periodic_timer0_capture_input,
    input wire logic uart_rx,
    input wire logic low_power,
    input wire logic wake
);
    // shadows follow completed writes, one cycle behind the real registers,
    // which lines them up with the registered pin outputs
    logic [7:0] sel_lo_r, insrc_r, wen_r;
    logic [1:0] up_r;
    wire logic wr_ok = psel && penable && pready && pwrite && !pslverr;
    wire logic live = (up_r == 2'h2);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {sel_lo_r, insrc_r, wen_r} <= 24'h000000;
            up_r <= 2'h0;
        end else begin
            if (!live)
                up_r <= up_r + 2'h1;
            if (wr_ok && paddr == PEMUX_OFS_PESEL_LO)
                sel_lo_r <= pwdata[7:0];
            if (wr_ok && paddr == PEMUX_OFS_INSRC)
                insrc_r <= pwdata[7:0];
            if (wr_ok && paddr == PEMUX_OFS_PA_WAKE)
                wen_r <= pwdata[7:0];
        end
    end
    AST_PE3_TIMER: assert property (live && $stable(sel_lo_r) && sel_lo_r[7:6] == 2'h1 |->
        !port_e_oen[3] && port_e_out[3] == $past(compact_timer1_output)) else $error("pe3 bad");
    AST_PE0_TX: assert property (live && $stable(sel_lo_r) && sel_lo_r[1:0] == 2'h1 |->
        !port_e_oen[0] && port_e_out[0] == $past(uart_tx)) else $error("pe0 bad");
    AST_CT1_CLK: assert property (live |->
        compact_timer1_clock_input == $past(port_e_in[2])) else $error("ct1 clock bad");
    AST_UART_SRC: assert property (live && $stable(insrc_r) && insrc_r[7:6] == 2'h0 |->
        uart_rx == $past(port_c_bit2)) else $error("uart rx source bad");
    AST_PT0_CAP: assert property (live && $stable(insrc_r) |->
        periodic_timer0_capture_input == $past(insrc_r[3:2] == 2'h0 ? port_a_in[0] : port_a_in[1]))
        else $error("pt0 capture bad");
    AST_ST0_CAP: assert property (live && $stable(insrc_r) |->
        standard_timer0_capture_input == $past(insrc_r[1:0] == 2'h0 ? port_e_in[5] : port_e_in[6]))
        else $error("st0 capture bad");
    AST_WAKE_FALL: assert property (live && low_power && $stable(wen_r) &&
        |(wen_r & $past(port_a_in) & ~port_a_in) |=> wake) else $error("missed wake");
    AST_WAKE_CAUSE: assert property (live && wake |-> $past(low_power))
        else $error("wake while awake");
    AST_RST_PORTS: assert property ($rose(presetn) |-> port_e_oen == 8'hFF &&
        port_e_out == 8'hFF && port_a_oen == 8'hFF) else $error("port reset bad");
    cover property (wake);
    cover property (pready && pslverr);
    cover property (live && sel_lo_r[7:6] == 2'h1);
endmodule : pemux_chk
`default_nettype wire

// file: verif/pemux_pins.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// external circuitry on the shared pins
// ----------------------------------------
module pemux_pins (
    input wire logic [7:0] e_out,
    input wire logic [7:0] e_oen,
    input wire logic [7:0] e_ext,
    input wire logic [7:0] a_out,
    input wire logic [7:0] a_oen,
    input wire logic [7:0] a_ext,
    output logic [7:0] e_pin,
    output logic [7:0] a_pin
);
    // a driven pin shows the device, a released one the outside level
    assign e_pin = (~e_oen & e_out) | (e_oen & e_ext);
    assign a_pin = (~a_oen & a_out) | (a_oen & a_ext);
endmodule : pemux_pins
`default_nettype wire

// file: verif/pemux_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port e pin mux bench
// ----------------------------------------
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
$display("CHECK FAILED %0t got %h exp %h", $time, (g), (e)); end end
module tb;
    import pemux_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tog = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_v;
    logic pready, pslverr, er_v, wake, uart_rx;
    logic [7:0] port_e_in, port_e_out, port_e_oen, port_a_in, port_a_out, port_a_oen;
    logic [7:0] ext_e = 8'h00, ext_a = 8'hFF, wake_cnt = 8'h00;
    logic port_c_bit2 = 1'b0, compact_timer1_output = 1'b0, standard_timer0_output = 1'b0;
    logic uart_tx = 1'b0, low_power = 1'b0;
    logic compact_timer1_clock_input, standard_timer0_clock_input;
    logic standard_timer0_capture_input, periodic_timer0_capture_input;
    logic periodic_timer1_capture_input;
    int mismatches = 0, num_checks = 0;
    wire logic [3:0] caps = {uart_rx, periodic_timer1_capture_input,
        periodic_timer0_capture_input, standard_timer0_capture_input};
    wire logic [1:0] clks = {compact_timer1_clock_input, standard_timer0_clock_input};
    pemux_top u_pemux_top (.*);
    pemux_pins u_pemux_pins (.e_out(port_e_out), .e_oen(port_e_oen), .e_ext(ext_e),
        .a_out(port_a_out), .a_oen(port_a_oen), .a_ext(ext_a), .e_pin(port_e_in),
        .a_pin(port_a_in));
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        if (tog) begin
            compact_timer1_output <= ~compact_timer1_output;
            standard_timer0_output <= ~standard_timer0_output;
            uart_tx <= ~uart_tx;
        end
        if (wake === 1'b1)
            wake_cnt <= wake_cnt + 8'h01;
    end
    // one idle cycle between transfers keeps each signal to one update per step
    // only the watchdog ends a wait for the answer
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_v = prdata;
        er_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask : wr
    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd_v, {24'h000000, e})
        `CHK(er_v, 1'b0)
    endtask : rchk
    task automatic print_verdict();
        if (mismatches == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rchk(PEMUX_OFS_PE_DATA, 8'hFF);
        rchk(PEMUX_OFS_PE_DIR, 8'hFF);
        rchk(PEMUX_OFS_PA_WAKE, 8'h00);
        apb(1'b0, 12'h030, 32'h0);
        `CHK(er_v, 1'b1)
        wr(PEMUX_OFS_PE_DIR, 8'h00);
        repeat (2) @(posedge pclk);
        `CHK({port_e_out, port_e_oen}, 16'hFF00)
        for (int c = 0; c < 4; c++) begin
            wr(PEMUX_OFS_PESEL_LO, {4{2'(c + 2)}});
            wr(PEMUX_OFS_PESEL_HI, {4{2'(c + 2)}});
            repeat (2) @(posedge pclk);
            `CHK(port_e_out, (c == 3) ? 8'h96 : 8'hFF)
            rchk(PEMUX_OFS_PESEL_HI, {4{2'(c + 2)}});
        end
        tog <= 1'b1;
        wr(PEMUX_OFS_PE_DIR, 8'hFF);
        wr(PEMUX_OFS_PESEL_LO, 8'h04);
        // timer functions off again so pins 5 and 6 show the outside level
        wr(PEMUX_OFS_PESEL_HI, 8'h00);
        ext_e <= 8'h34;
        ext_a <= 8'h09;
        port_c_bit2 <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(PEMUX_OFS_INSRC, {4{2'(c)}});
            repeat (2) @(posedge pclk);
            `CHK(caps, (c == 0) ? 4'hF : 4'h0)
        end
        `CHK(clks, 2'h3)
        ext_e <= 8'hA5;
        repeat (2) @(posedge pclk);
        `CHK(clks, 2'h2)
        wr(PEMUX_OFS_PE_BITOP, 8'h02);
        rchk(PEMUX_OFS_PE_DATA, 8'hA1);
        wr(PEMUX_OFS_PE_BITOP, 8'h17);
        rchk(PEMUX_OFS_PE_DIR, 8'h7F);
        `CHK({port_e_oen, port_e_out[7]}, 9'h0FF)
        wr(PEMUX_OFS_PA_WAKE, 8'h02);
        ext_a <= 8'hFF;
        low_power <= 1'b1;
        repeat (3) @(posedge pclk);
        ext_a <= 8'hFE;
        repeat (3) @(posedge pclk);
        `CHK(wake_cnt, 8'h00)
        ext_a <= 8'hFC;
        repeat (3) @(posedge pclk);
        `CHK(wake_cnt, 8'h01)
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        print_verdict();
    end
endmodule : tb
bind pemux_top pemux_chk u_pemux_chk (.*);
`default_nettype wire
